// ### src/ppom_pkg.sv
package ppom_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] PORT1_MODE_FIRST_ADDR = 8'hD4;
  localparam logic [7:0] PORT3_MODE_FIRST_ADDR = 8'hD5;
  localparam logic [7:0] PORT1_MODE_SECOND_ADDR = 8'hE2;
  localparam logic [7:0] PORT3_MODE_SECOND_ADDR = 8'hE4;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam int PORT_WIDTH = 8;
  // ==========================================================
  // timing
  localparam int STRONG_PULSE_CLOCKS = 2;
  // ==========================================================
  // output modes, {first bit, second bit}
  typedef enum logic [1:0] {
    PPOM_QUASI = 2'b00,
    PPOM_PUSH_PULL = 2'b01,
    PPOM_INPUT_ONLY = 2'b10,
    PPOM_OPEN_DRAIN = 2'b11
  } ppom_mode_type;
endpackage : ppom_pkg

// ### src/ppom_drv_if.sv
`timescale 1ns/1ns
interface ppom_drv_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] mode_first;
  logic [WIDTH-1:0] mode_second;
  logic [WIDTH-1:0] latch;
  logic [WIDTH-1:0] pin_sync;
  logic [WIDTH-1:0] very_weak_up;
  logic [WIDTH-1:0] weak_up;
  logic [WIDTH-1:0] strong_up;
  logic [WIDTH-1:0] pull_down;
  modport ctrl (output mode_first, mode_second, latch, pin_sync,
                input very_weak_up, weak_up, strong_up, pull_down);
  modport drv (input mode_first, mode_second, latch, pin_sync,
               output very_weak_up, weak_up, strong_up, pull_down);
endinterface : ppom_drv_if

// ### src/ppom_port_drv.sv
`timescale 1ns/1ns
// ==========================================================
// per-pin driver decode for one port
module ppom_port_drv #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  ppom_drv_if.drv bus
);
  localparam int PW = $clog2(ppom_pkg::STRONG_PULSE_CLOCKS + 1);
  localparam logic [PW-1:0] PULSE_LOAD = PW'(ppom_pkg::STRONG_PULSE_CLOCKS);
  localparam logic [PW-1:0] PULSE_ONE = PW'(1);

  if (WIDTH < 1) begin : g_bad_width
    $error("ppom_port_drv: WIDTH must be positive");
  end
  // a zero-length boost would leave the pulse counter without a load value
  if (ppom_pkg::STRONG_PULSE_CLOCKS < 1) begin : g_bad_pulse
    $error("ppom_port_drv: strong pulse needs at least one clock");
  end

  logic [WIDTH-1:0] latch_prev_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      latch_prev_q <= '1;
    end else begin
      latch_prev_q <= bus.latch;
    end
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_pin
      ppom_pkg::ppom_mode_type mode;
      logic [PW-1:0] pulse_q;
      logic rise;
      logic is_quasi;
      assign mode = ppom_pkg::ppom_mode_type'({bus.mode_first[i], bus.mode_second[i]});
      assign is_quasi = (mode == ppom_pkg::PPOM_QUASI);
      assign rise = bus.latch[i] & ~latch_prev_q[i];
      // two-clock boost on latch 0->1; a drop of the latch cuts it short
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          pulse_q <= '0;
        end else if (is_quasi && rise) begin
          pulse_q <= PULSE_LOAD;
        end else if (pulse_q != '0 && bus.latch[i] && is_quasi) begin
          pulse_q <= pulse_q - PULSE_ONE;
        end else begin
          pulse_q <= '0;
        end
      end
      assign bus.very_weak_up[i] = is_quasi & bus.latch[i];
      assign bus.weak_up[i] = is_quasi & bus.latch[i] & bus.pin_sync[i];
      assign bus.strong_up[i] = ((mode == ppom_pkg::PPOM_PUSH_PULL) & bus.latch[i])
                               | (is_quasi & bus.latch[i] & (pulse_q != '0));
      // boost gated by latch and mode so a cut pulse never fights the pull-down
      // pull-down shared by every driving mode; input-only drives nothing
      assign bus.pull_down[i] = (mode != ppom_pkg::PPOM_INPUT_ONLY) & ~bus.latch[i];
    end
  endgenerate
endmodule : ppom_port_drv

// ### src/ppom_top.sv
`timescale 1ns/1ns
// Overview of operation
// - reset puts all pins quasi-bidirectional
// - quasi: very weak pull-up when latch high
// - quasi: weak pull-up when latch, pin high
// - pin pulled low leaves only very weak
// - quasi latch rise: strong pull-up two clocks
// - quasi: latch low enables strong pull-down
// - open drain: no pull-ups, pull-down latch low
// - push-pull: continuous strong up, latch high
// - input only: nothing driven, high impedance
// - first port modes at D4h and E2h
// - second port modes at D5h and E4h
// - mode bits: 00 quasi, 01 pp, 10 in, 11 od
module ppom_top (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  input wire logic [7:0] first_port_latch,
  input wire logic [7:0] second_port_latch,
  input wire logic [7:0] first_port_pin,
  input wire logic [7:0] second_port_pin,
  output logic [7:0] first_port_level,
  output logic [7:0] second_port_level,
  output logic [7:0] first_port_very_weak_up,
  output logic [7:0] first_port_weak_up,
  output logic [7:0] first_port_strong_up,
  output logic [7:0] first_port_pull_down,
  output logic [7:0] second_port_very_weak_up,
  output logic [7:0] second_port_weak_up,
  output logic [7:0] second_port_strong_up,
  output logic [7:0] second_port_pull_down
);
  localparam int W = ppom_pkg::PORT_WIDTH;

  // the pin ports are fixed at eight bits, so the package width must match
  if (W != 8) begin : g_bad_width
    $error("ppom_top: port width must be eight");
  end

  // ==========================================================
  // mode registers
  logic [W-1:0] p1_first_q;
  logic [W-1:0] p1_second_q;
  logic [W-1:0] p3_first_q;
  logic [W-1:0] p3_second_q;

  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] target);
    return addr == target;
  endfunction : addr_is

  wire sel_p1f = addr_is(sfr_addr, ppom_pkg::PORT1_MODE_FIRST_ADDR);
  wire sel_p1s = addr_is(sfr_addr, ppom_pkg::PORT1_MODE_SECOND_ADDR);
  wire sel_p3f = addr_is(sfr_addr, ppom_pkg::PORT3_MODE_FIRST_ADDR);
  wire sel_p3s = addr_is(sfr_addr, ppom_pkg::PORT3_MODE_SECOND_ADDR);
  wire any_sel = sel_p1f | sel_p1s | sel_p3f | sel_p3s;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      p1_first_q <= ppom_pkg::MODE_RESET;
      p1_second_q <= ppom_pkg::MODE_RESET;
      p3_first_q <= ppom_pkg::MODE_RESET;
      p3_second_q <= ppom_pkg::MODE_RESET;
    end else if (sfr_wr) begin
      if (sel_p1f) p1_first_q <= sfr_wdata;
      if (sel_p1s) p1_second_q <= sfr_wdata;
      if (sel_p3f) p3_first_q <= sfr_wdata;
      if (sel_p3s) p3_second_q <= sfr_wdata;
    end
  end

  // ==========================================================
  // read path: unmapped addresses read zero and leave hit low
  wire [7:0] rdata_d = sel_p1f ? p1_first_q :
                       sel_p1s ? p1_second_q :
                       sel_p3f ? p3_first_q :
                       sel_p3s ? p3_second_q : 8'h00;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
      sfr_hit <= 1'b0;
    end else begin
      sfr_rdata <= sfr_rd ? rdata_d : 8'h00;
      sfr_hit <= sfr_rd & any_sel;
    end
  end

  // ==========================================================
  // pin synchronisers; level is taken from the second stage only
  logic [W-1:0] p1_meta_q;
  logic [W-1:0] p1_sync_q;
  logic [W-1:0] p3_meta_q;
  logic [W-1:0] p3_sync_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      p1_meta_q <= '0;
      p1_sync_q <= '0;
      p3_meta_q <= '0;
      p3_sync_q <= '0;
    end else begin
      p1_meta_q <= first_port_pin;
      p1_sync_q <= p1_meta_q;
      p3_meta_q <= second_port_pin;
      p3_sync_q <= p3_meta_q;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      first_port_level <= '0;
      second_port_level <= '0;
    end else begin
      first_port_level <= p1_sync_q;
      second_port_level <= p3_sync_q;
    end
  end

  // ==========================================================
  // driver decode per port
  ppom_drv_if #(.WIDTH(W)) p1_if ();
  ppom_drv_if #(.WIDTH(W)) p3_if ();

  assign p1_if.mode_first = p1_first_q;
  assign p1_if.mode_second = p1_second_q;
  assign p1_if.latch = first_port_latch;
  assign p1_if.pin_sync = p1_sync_q;
  assign p3_if.mode_first = p3_first_q;
  assign p3_if.mode_second = p3_second_q;
  assign p3_if.latch = second_port_latch;
  assign p3_if.pin_sync = p3_sync_q;

  ppom_port_drv #(.WIDTH(W)) u_p1 (
    .clk_sys(clk_sys),
    .rst(rst),
    .bus(p1_if.drv)
  );

  ppom_port_drv #(.WIDTH(W)) u_p3 (
    .clk_sys(clk_sys),
    .rst(rst),
    .bus(p3_if.drv)
  );

  // ==========================================================
  // registered enables; costs one clock of lag but keeps pads glitch-free
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      first_port_very_weak_up <= '0;
      first_port_weak_up <= '0;
      first_port_strong_up <= '0;
      first_port_pull_down <= '0;
      second_port_very_weak_up <= '0;
      second_port_weak_up <= '0;
      second_port_strong_up <= '0;
      second_port_pull_down <= '0;
    end else begin
      first_port_very_weak_up <= p1_if.very_weak_up;
      first_port_weak_up <= p1_if.weak_up;
      first_port_strong_up <= p1_if.strong_up;
      first_port_pull_down <= p1_if.pull_down;
      second_port_very_weak_up <= p3_if.very_weak_up;
      second_port_weak_up <= p3_if.weak_up;
      second_port_strong_up <= p3_if.strong_up;
      second_port_pull_down <= p3_if.pull_down;
    end
  end
endmodule : ppom_top

// ### sim/ppom_assertions.sv
`timescale 1ns/1ns
// ==========================================================
// port-level checker; mode registers are shadowed from the bus
module ppom_assertions (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_hit,
  input wire logic [7:0] first_port_latch,
  input wire logic [7:0] first_port_pin,
  input wire logic [7:0] first_port_level,
  input wire logic [7:0] first_port_very_weak_up,
  input wire logic [7:0] first_port_weak_up,
  input wire logic [7:0] first_port_strong_up,
  input wire logic [7:0] first_port_pull_down
);
  logic [7:0] f1_q;
  logic [7:0] f2_q;
  logic [1:0] cnt_q;
  // skip three edges after reset so $past never looks into reset
  wire live = (cnt_q == 2'h3);
  wire [7:0] qs = ~(f1_q | f2_q);
  wire [7:0] lt = first_port_latch;
  wire [7:0] pd_e = ~lt & ~(f1_q & ~f2_q);
  wire [7:0] vw_e = lt & qs;
  wire [7:0] pp_e = lt & ~f1_q & f2_q;
  wire [7:0] ups = first_port_very_weak_up | first_port_weak_up | first_port_strong_up;
  wire wa = sfr_wr && (sfr_addr == ppom_pkg::PORT1_MODE_FIRST_ADDR);
  wire wb = sfr_wr && (sfr_addr == ppom_pkg::PORT1_MODE_SECOND_ADDR);
  wire mapped = sfr_addr inside {ppom_pkg::PORT1_MODE_FIRST_ADDR, ppom_pkg::PORT3_MODE_FIRST_ADDR,
    ppom_pkg::PORT1_MODE_SECOND_ADDR, ppom_pkg::PORT3_MODE_SECOND_ADDR};
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      f1_q <= 8'h00;
      f2_q <= 8'h00;
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= live ? cnt_q : cnt_q + 2'h1;
      f1_q <= wa ? sfr_wdata : f1_q;
      f2_q <= wb ? sfr_wdata : f2_q;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  pull_down_a: assert property (live |-> first_port_pull_down == $past(pd_e))
    else $error("pull-down enable wrong");
  very_weak_a: assert property (live |-> first_port_very_weak_up == $past(vw_e))
    else $error("very weak pull-up wrong");
  weak_up_a: assert property (live |-> first_port_weak_up == ($past(vw_e) & first_port_level))
    else $error("weak pull-up wrong");
  push_up_a: assert property (live |-> (first_port_strong_up & ~$past(qs)) == $past(pp_e))
    else $error("push-pull strong pull-up wrong");
  no_up_a: assert property (live |-> (ups & $past(f1_q)) == 8'h00)
    else $error("pull-up on in open drain or input only");
  // boost is loaded on the edge that sees the rise, then shows through the output register
  strong_boost_a: assert property (live && $rose(lt[0]) && qs[0] ##1 lt[0] && qs[0]
    ##1 lt[0] && qs[0] |-> first_port_strong_up[0] ##1 first_port_strong_up[0]
    ##1 (!first_port_strong_up[0] || !$past(qs[0])))
    else $error("strong pull-up pulse not two clocks");
  pin_level_a: assert property (live |-> first_port_level == $past(first_port_pin, 3))
    else $error("pin level not passed through");
  mode_read_a: assert property (sfr_rd && sfr_addr == ppom_pkg::PORT1_MODE_FIRST_ADDR
    |=> sfr_hit && sfr_rdata == $past(f1_q))
    else $error("mode register read back wrong");
  unmapped_a: assert property (sfr_rd && !mapped |=> !sfr_hit && sfr_rdata == 8'h00)
    else $error("unmapped read answered");
  boost_c: cover property ($rose(first_port_strong_up[0]));
  read_c: cover property (sfr_hit);
  weak_c: cover property (first_port_weak_up != 8'h00);
endmodule : ppom_assertions

// ### sim/ppom_pins.sv
`timescale 1ns/1ns
// ==========================================================
// pins with an external pull-low; undriven pins wander each cycle
module ppom_pins (
  input wire logic clk_sys,
  input wire logic [7:0] up,
  input wire logic [7:0] pd,
  input wire logic [7:0] ext_low,
  output logic [7:0] pin
);
  logic t_q = 1'h0;
  always_ff @(posedge clk_sys) t_q <= ~t_q;
  assign pin = ~pd & ~ext_low & (up | {8{t_q}});
endmodule : ppom_pins

// ### sim/tb_port_pin_output_modes.sv
`timescale 1ns/1ns
// ==========================================================
// bench: bus-cycle tasks, then latch and pin stimulus
module tb_port_pin_output_modes;
  logic clk_sys, rst, sfr_wr, sfr_rd, sfr_hit;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, first_port_latch, second_port_latch;
  logic [7:0] first_port_pin, second_port_pin, first_port_level, second_port_level;
  logic [7:0] first_port_very_weak_up, first_port_weak_up, first_port_strong_up;
  logic [7:0] second_port_very_weak_up, second_port_weak_up, second_port_strong_up;
  logic [7:0] first_port_pull_down, second_port_pull_down, ext_low;
  logic [7:0] adr [4] = '{8'hD4, 8'hD5, 8'hE2, 8'hE4};
  logic [7:0] dat [4] = '{8'h0C, 8'hF0, 8'h0A, 8'h33};
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  ppom_top uut (.*);
  ppom_pins ext1 (.clk_sys(clk_sys),
    .up(first_port_very_weak_up | first_port_weak_up | first_port_strong_up),
    .pd(first_port_pull_down), .ext_low(ext_low), .pin(first_port_pin));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'h1;
    @(posedge clk_sys);
    sfr_wr <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic h);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_rd <= 1'h1;
    @(posedge clk_sys);
    sfr_rd <= 1'h0;
    @(negedge clk_sys);
    check(sfr_rdata, exp);
    check({7'h00, sfr_hit}, {7'h00, h});
  endtask : rd
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  initial begin
    clk_sys = 1'h0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      wrap_up();
    end
  end
  initial begin
    {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = 18'h00000;
    {first_port_latch, second_port_latch, second_port_pin} = 24'hFFFFFF;
    ext_low = 8'h0C;
    rst = 1'h1;
    repeat (5) @(posedge clk_sys);
    rst <= 1'h0;
    for (int i = 0; i < 4; i++) rd(adr[i], 8'h00, 1'h1);
    for (int i = 0; i < 4; i++) wr(adr[i], dat[i]);
    wr(8'hD6, 8'hFF);
    rd(8'hD6, 8'h00, 1'h0);
    for (int i = 0; i < 4; i++) rd(adr[i], dat[i], 1'h1);
    @(posedge clk_sys);
    first_port_latch <= 8'h00;
    second_port_latch <= 8'h00;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    check(first_port_pull_down, 8'hFB);
    check(second_port_pull_down, 8'h3F);
    @(posedge clk_sys);
    first_port_latch <= 8'hFF;
    second_port_latch <= 8'hFF;
    @(posedge clk_sys);
    // boost is loaded on the edge that sees the rise, so it shows one cycle later
    @(negedge clk_sys);
    check(first_port_strong_up, 8'h02);
    check(first_port_very_weak_up, 8'hF1);
    for (int i = 0; i < 2; i++) begin
      @(negedge clk_sys);
      check(first_port_strong_up, 8'hF3);
      check(second_port_strong_up, 8'h0F);
    end
    @(negedge clk_sys);
    check(first_port_strong_up, 8'h02);
    repeat (4) @(negedge clk_sys);
    check(first_port_strong_up, 8'h02);
    check(second_port_strong_up, 8'h03);
    check(first_port_weak_up, 8'hF1);
    check(first_port_level, 8'hF3);
    check(second_port_very_weak_up, 8'h0C);
    check(second_port_weak_up, 8'h0C);
    check(second_port_level, 8'hFF);
    @(posedge clk_sys);
    ext_low <= 8'h0D;
    second_port_pin <= 8'hFB;
    repeat (5) @(negedge clk_sys);
    check(first_port_weak_up, 8'hF0);
    check(first_port_very_weak_up, 8'hF1);
    check(first_port_level, 8'hF2);
    check(second_port_weak_up, 8'h08);
    check(second_port_very_weak_up, 8'h0C);
    check(second_port_level, 8'hFB);
    // second reset with every mode register written
    @(posedge clk_sys);
    rst <= 1'h1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'h0;
    for (int i = 0; i < 4; i++) rd(adr[i], 8'h00, 1'h1);
    @(negedge clk_sys);
    check(first_port_very_weak_up, 8'hFF);
    check(second_port_pull_down, 8'h00);
    wrap_up();
  end
endmodule : tb_port_pin_output_modes
bind ppom_top ppom_assertions chk (.*);
